// *** verilog/tswd_watchdog_unit.sv ***
// Two-stage watchdog unit: configuration space, memory window and pin block.
// Assumes one 10 MHz clock, synchronous strobes, one access per space per cycle.
//
// Notes on behaviour
// - 35-bit down-counter starts from first preload
// - First expiry flags interrupt, loads second preload
// - Second expiry drives timeout low until reset
// - Preloads at 00H/04H, twenty writable bits
// - Preload write needs 80H then 86H first
// - Status bit 0 set at first expiry
// - Unlock then bit 8 write reloads counter
// - Config bit 5 disables timeout output
// - Config bit 2 picks microsecond or millisecond
// - Config bits 1:0 pick interrupt type
// - IRQ is active-low level request
// - Lock bit 1 enables, clearing stops timer
// - Lock bit 0 freezes register until reset
// - Pin-use bit 0 selects timeout or general
// - Low reset gate lets timeout reset system
// - Indicator follows level bit 24 when output
// - Blink bit toggles indicator each half second
`include "tswd_regs.svh"

module tswd_watchdog_unit
	import tswd_pkg::*;
#(
	parameter int unsigned MS_CYCLES    = `TSWD_MS_CYCLES,    // Cycles per millisecond tick
	parameter int unsigned BLINK_CYCLES = `TSWD_BLINK_CYCLES  // Cycles per blink phase
) (
	input  wire logic        clk_in,                 // 10 MHz clock
	input  wire logic        rst_b_in,               // Hard reset, synchronous, low
	input  wire tswd_access_s cfg_acc_in,            // Configuration space access
	input  wire tswd_access_s win_acc_in,            // Memory window access
	input  wire tswd_access_s pin_acc_in,            // Pin block access
	input  wire logic        shared_general_pin_in,  // General level on shared pin
	output logic [31:0]      cfg_rdata_out,          // Config read data
	output logic [31:0]      win_rdata_out,          // Window read data
	output logic [31:0]      pin_rdata_out,          // Pin block read data
	output logic             irq_n_out,              // Interrupt request, active low
	output logic             management_interrupt_out, // Reserved path, held low
	output logic             timeout_out_n,          // Watchdog timeout, active low
	output logic             shared_general_pin_out, // Shared pin output level
	output logic             shared_general_pin_oe_out, // Shared pin drive enable
	output logic             reset_gate_output,      // Reset-circuit gate level
	output logic             indicator_output        // LED drive, low lights
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [`TSWD_CNT_W-1:0]     count_q;      // Main down-counter
	logic [`TSWD_PRELOAD_W-1:0] preload1_q;   // First stage load
	logic [`TSWD_PRELOAD_W-1:0] preload2_q;   // Second stage load
	logic                       status_q;     // First-stage interrupt pending
	logic                       expired_q;    // Second expiry seen
	tswd_stage_e                stage_q;      // Counter stage
	tswd_unlock_e               unlock_q;     // Unlock tracker
	logic [15:0]                config_q;     // Configuration register
	logic [7:0]                 lock_q;       // Enable and freeze bits
	logic [31:0]                base_q;       // Window base address
	logic [31:0]                dir_q;        // Pin direction, 0 = output
	logic [31:0]                level_q;      // Pin output levels
	logic [31:0]                blink_q;      // Pin blink enables
	logic [31:0]                use_q;        // Pin function select
	logic [19:0]                pre_q;        // Prescaler counter
	logic [22:0]                blink_cnt_q;  // Blink phase counter
	logic                       blink_ph_q;   // Blink phase level

	logic enabled;     // Timer running
	logic tick;        // One time-base step
	logic win_wr;      // Window write strobe
	logic key_ok;      // Unlock pair complete
	logic reload_req;  // Valid reload command
	logic [19:0] tick_cycles; // Selected prescale length

	assign enabled = lock_q[`TSWD_LOCK_ENABLE];
	assign win_wr  = win_acc_in.wr;
	assign key_ok  = (unlock_q == TSWD_OPEN);
	// A reload only counts right after the full pair
	assign reload_req = win_wr && key_ok && (win_acc_in.addr == `TSWD_OFF_RELOAD)
		&& win_acc_in.wdata[`TSWD_RELOAD_BIT];

	// Prescaler length by base selection
	assign tick_cycles = config_q[`TSWD_CFG_PRESCALE] ? 20'(`TSWD_US_CYCLES)
		: 20'(MS_CYCLES);
	assign tick = enabled && (pre_q == tick_cycles - 20'h1);

	// ----------------------------------------------------------------
	// Prescaler
	// ----------------------------------------------------------------
	// Restarts on reload so each service gives a full period
	// Counts only while enabled; disabling clears it
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || !enabled || reload_req || tick) begin
			pre_q <= 20'h0;
		end else begin
			pre_q <= pre_q + 20'h1;
		end
	end

	// ----------------------------------------------------------------
	// Unlock tracking
	// ----------------------------------------------------------------
	// Any other write breaks the sequence, so keys never linger
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			unlock_q <= TSWD_LOCKED;
		end else if (win_wr) begin
			if (win_acc_in.addr == `TSWD_OFF_RELOAD
				&& win_acc_in.wdata == `TSWD_KEY_FIRST) begin
				unlock_q <= TSWD_KEY1_SEEN;
			end else if (unlock_q == TSWD_KEY1_SEEN && win_acc_in.addr == `TSWD_OFF_RELOAD
				&& win_acc_in.wdata == `TSWD_KEY_SECOND) begin
				unlock_q <= TSWD_OPEN;
			end else begin
				unlock_q <= TSWD_LOCKED;
			end
		end
	end

	// ----------------------------------------------------------------
	// Preload registers
	// ----------------------------------------------------------------
	// Only the write right after the key pair lands
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			preload1_q <= '0;
			preload2_q <= '0;
		end else if (win_wr && key_ok) begin
			// Upper bits are dropped, only twenty bits store
			if (win_acc_in.addr == `TSWD_OFF_PRELOAD1) begin
				preload1_q <= win_acc_in.wdata[`TSWD_PRELOAD_W-1:0];
			end
			if (win_acc_in.addr == `TSWD_OFF_PRELOAD2) begin
				preload2_q <= win_acc_in.wdata[`TSWD_PRELOAD_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Stage machine and down-counter
	// ----------------------------------------------------------------
	// Reload beats an expiry tick that lands in the same cycle
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			stage_q <= TSWD_IDLE;
			count_q <= '0;
		end else if (!enabled) begin
			// Disabling stops and rearms from the first stage
			stage_q <= TSWD_IDLE;
		end else begin
			case (stage_q)
				// Entering the first stage from rest
				TSWD_IDLE: begin
					stage_q <= TSWD_STAGE1;
					count_q <= `TSWD_CNT_W'(preload1_q);
				end
				TSWD_STAGE1, TSWD_STAGE2: begin
					if (reload_req) begin
						stage_q <= TSWD_STAGE1;
						count_q <= `TSWD_CNT_W'(preload1_q);
					end else if (tick && count_q == '0) begin
						if (stage_q == TSWD_STAGE1) begin
							stage_q <= TSWD_STAGE2;
							count_q <= `TSWD_CNT_W'(preload2_q);
						end else begin
							stage_q <= TSWD_EXPIRED;
						end
					end else if (tick) begin
						count_q <= count_q - `TSWD_CNT_W'(1);
					end
				end
				TSWD_EXPIRED: begin
					stage_q <= TSWD_EXPIRED; // Held until reset or disable
				end
				default: begin
					// Unused code, fall back to rest
					stage_q <= TSWD_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// First-stage status and timeout latch
	// ----------------------------------------------------------------
	// Status clears only by reset; no clear path is given
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			status_q  <= 1'b0;
			expired_q <= 1'b0;
		end else begin
			// Expiry during a reload is dropped, the reload wins
			if (enabled && stage_q == TSWD_STAGE1 && tick && count_q == '0 && !reload_req) begin
				status_q <= 1'b1;
			end
			if (enabled && stage_q == TSWD_STAGE2 && tick && count_q == '0 && !reload_req) begin
				expired_q <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration space
	// ----------------------------------------------------------------
	// Plain writes; the lock register guards itself once frozen
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			config_q <= `TSWD_RST_CONFIG;
			lock_q   <= `TSWD_RST_LOCK; // Unlocked by default
			base_q   <= `TSWD_RST_PIN_REG;
		end else if (cfg_acc_in.wr) begin
			case (cfg_acc_in.addr)
				`TSWD_CFG_CONFIG:    config_q <= cfg_acc_in.wdata[15:0];
				`TSWD_CFG_BASE_ADDR: base_q   <= cfg_acc_in.wdata;
				`TSWD_CFG_LOCK: begin
					// Frozen contents hold until hard reset
					if (!lock_q[`TSWD_LOCK_FREEZE]) begin
						lock_q <= cfg_acc_in.wdata[7:0];
					end
				end
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pin block registers
	// ----------------------------------------------------------------
	// Direction and level reset high so pins idle inactive
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			dir_q   <= `TSWD_RST_DIR_REG;
			level_q <= `TSWD_RST_PIN_LEVEL;
			blink_q <= `TSWD_RST_PIN_REG;
			use_q   <= `TSWD_RST_PIN_REG;
		end else if (pin_acc_in.wr) begin
			case (pin_acc_in.addr)
				`TSWD_PIN_DIRECTION: dir_q   <= pin_acc_in.wdata;
				`TSWD_PIN_LEVEL:     level_q <= pin_acc_in.wdata;
				`TSWD_PIN_BLINK:     blink_q <= pin_acc_in.wdata;
				`TSWD_PIN_USE:       use_q   <= pin_acc_in.wdata;
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Blink generator
	// ----------------------------------------------------------------
	// Free-running; the enable only picks the phase, so a
	// newly enabled blink may start mid-phase
	always_ff @(posedge clk_in) begin
		if (!rst_b_in || blink_cnt_q == 23'(BLINK_CYCLES - 1)) begin
			blink_cnt_q <= 23'h0;
		end else begin
			blink_cnt_q <= blink_cnt_q + 23'h1;
		end
		if (!rst_b_in) begin
			blink_ph_q <= 1'b0;
		end else if (blink_cnt_q == 23'(BLINK_CYCLES - 1)) begin
			blink_ph_q <= !blink_ph_q;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	// Every pin comes from a flop, so pins trail state by a cycle
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_n_out                 <= 1'b1;
			management_interrupt_out  <= 1'b0;
			timeout_out_n             <= 1'b1;
			shared_general_pin_out    <= 1'b1;
			shared_general_pin_oe_out <= 1'b0;
			reset_gate_output         <= 1'b1;
			indicator_output          <= 1'b1;
		end else begin
			// Level request while pending and type is IRQ
			irq_n_out <= !(status_q
				&& config_q[1:0] == `TSWD_IRQ_TYPE_IRQ);
			// Management path unsupported, never asserted
			management_interrupt_out <= 1'b0;
			// Timeout pin only in watchdog function and when allowed
			timeout_out_n <= !(expired_q && !config_q[`TSWD_CFG_TOUT_DIS]
				&& !use_q[`TSWD_USE_BIT]);
			shared_general_pin_out <= use_q[`TSWD_USE_BIT] ? level_q[0]
				: !(expired_q && !config_q[`TSWD_CFG_TOUT_DIS]);
			shared_general_pin_oe_out <= 1'b1;
			// Gate stays high (no reset) while not an output
			reset_gate_output <= dir_q[`TSWD_GATE_BIT] ? 1'b1
				: level_q[`TSWD_GATE_BIT];
			// Indicator: dark unless output; blink overrides level
			if (dir_q[`TSWD_LED_BIT]) begin
				indicator_output <= 1'b1;
			end else if (blink_q[`TSWD_LED_BIT]) begin
				indicator_output <= blink_ph_q;
			end else begin
				indicator_output <= level_q[`TSWD_GATE_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// Read data, one cycle after the address
	// ----------------------------------------------------------------
	// Address is decoded every cycle; no read strobe is needed
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cfg_rdata_out <= 32'h0;
			win_rdata_out <= 32'h0;
			pin_rdata_out <= 32'h0;
		end else begin
			case (cfg_acc_in.addr)
				`TSWD_CFG_CONFIG:    cfg_rdata_out <= {16'h0, config_q};
				`TSWD_CFG_LOCK:      cfg_rdata_out <= {24'h0, lock_q};
				`TSWD_CFG_BASE_ADDR: cfg_rdata_out <= base_q;
				default:             cfg_rdata_out <= 32'h0;
			endcase
			// Reload register is write-only and reads zero
			case (win_acc_in.addr)
				`TSWD_OFF_PRELOAD1:   win_rdata_out <= 32'(preload1_q);
				`TSWD_OFF_PRELOAD2:   win_rdata_out <= 32'(preload2_q);
				`TSWD_OFF_INT_STATUS: win_rdata_out <= {31'h0, status_q};
				default:              win_rdata_out <= 32'h0;
			endcase
			case (pin_acc_in.addr)
				`TSWD_PIN_DIRECTION: pin_rdata_out <= dir_q;
				`TSWD_PIN_LEVEL:     pin_rdata_out <= level_q;
				`TSWD_PIN_BLINK:     pin_rdata_out <= blink_q;
				// Shared pin level reads back only in general use
				`TSWD_PIN_USE:       pin_rdata_out <= {use_q[31:1],
					use_q[0] ? shared_general_pin_in : 1'b0};
				default:             pin_rdata_out <= 32'h0;
			endcase
		end
	end

endmodule // tswd_watchdog_unit

// *** verilog/tswd_regs.svh ***
// Register map, field positions, reset values and timing counts of the watchdog unit.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TSWD_REGS_SVH
`define TSWD_REGS_SVH

// Memory window offsets
`define TSWD_OFF_PRELOAD1     8'h00
`define TSWD_OFF_PRELOAD2     8'h04
`define TSWD_OFF_INT_STATUS   8'h08
`define TSWD_OFF_RELOAD       8'h0C
// Configuration space offsets
`define TSWD_CFG_BASE_ADDR    8'h10
`define TSWD_CFG_CONFIG       8'h60
`define TSWD_CFG_LOCK         8'h68
// Pin block offsets
`define TSWD_PIN_DIRECTION    8'h04
`define TSWD_PIN_LEVEL        8'h0C
`define TSWD_PIN_BLINK        8'h18
`define TSWD_PIN_USE          8'h30

// Unlock key values and reload bit
`define TSWD_KEY_FIRST        32'h0000_0080
`define TSWD_KEY_SECOND       32'h0000_0086
`define TSWD_RELOAD_BIT       8
// Field positions
`define TSWD_PRELOAD_W        20
`define TSWD_CNT_W            35
`define TSWD_CFG_TOUT_DIS     5
`define TSWD_CFG_PRESCALE     2
`define TSWD_LOCK_ENABLE      1
`define TSWD_LOCK_FREEZE      0
`define TSWD_GATE_BIT         24
`define TSWD_LED_BIT          25
`define TSWD_USE_BIT          0
// Interrupt type encodings
`define TSWD_IRQ_TYPE_IRQ     2'h0
`define TSWD_IRQ_TYPE_OFF     2'h3

// Reset values
`define TSWD_RST_CONFIG       16'h0000
`define TSWD_RST_LOCK         8'h00
`define TSWD_RST_PIN_REG      32'h0000_0000
`define TSWD_RST_DIR_REG      32'hFFFF_FFFF
`define TSWD_RST_PIN_LEVEL    32'hFFFF_FFFF

// Time base: clock 100 ns period
`define TSWD_CLK_PERIOD_NS    100
`define TSWD_TICK_US_NS       1000
`define TSWD_TICK_MS_NS       1000000
`define TSWD_BLINK_HALF_NS    500000000
`define TSWD_US_CYCLES        (`TSWD_TICK_US_NS / `TSWD_CLK_PERIOD_NS)
`define TSWD_MS_CYCLES        (`TSWD_TICK_MS_NS / `TSWD_CLK_PERIOD_NS)
`define TSWD_BLINK_CYCLES     (`TSWD_BLINK_HALF_NS / `TSWD_CLK_PERIOD_NS)

`endif

// *** verilog/tswd_pkg.sv ***
// Types shared by the watchdog unit and its bench.
// Assumes tswd_regs.svh is on the include path.
`include "tswd_regs.svh"

package tswd_pkg;

	// Stage of the down-counter
	typedef enum logic [1:0] {
		TSWD_IDLE,
		TSWD_STAGE1,
		TSWD_STAGE2,
		TSWD_EXPIRED
	} tswd_stage_e;

	// Unlock tracker
	typedef enum logic [1:0] {
		TSWD_LOCKED,
		TSWD_KEY1_SEEN,
		TSWD_OPEN
	} tswd_unlock_e;

	// One register access of any space
	typedef struct packed {
		logic        wr;    // Write strobe, one cycle
		logic        rd;    // Read strobe, one cycle
		logic [7:0]  addr;  // Byte offset within its space
		logic [31:0] wdata; // Write data
	} tswd_access_s;

endpackage : tswd_pkg

// *** tb/tswd_watchdog_unit_props.sv ***
// Port-level checker for the watchdog unit.
// Assumes it is bound onto each tswd_watchdog_unit instance.
module tswd_watchdog_unit_props
	import tswd_pkg::*;
#(
	parameter int BLINK_CYCLES = 8 // Cycles per blink phase
) (
	input wire logic         clk_in,
	input wire logic         rst_b_in,
	input wire tswd_access_s cfg_acc_in,
	input wire tswd_access_s pin_acc_in,
	input wire logic [31:0]  cfg_rdata_out,
	input wire logic         irq_n_out,
	input wire logic         management_interrupt_out,
	input wire logic         timeout_out_n,
	input wire logic         reset_gate_output,
	input wire logic         indicator_output
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// Shadow copies of the registers, rebuilt from writes
	// ----
	localparam int BLK_MAX = BLINK_CYCLES + 2; // Slack for phase start
	logic [15:0] cfg_q;  // Configuration copy
	logic [1:0]  lock_q; // Enable and freeze copy
	logic [31:0] dir_q;  // Direction copy
	logic [31:0] lvl_q;  // Level copy
	logic [31:0] blk_q;  // Blink copy
	logic        led_prev_q;  // Indicator one cycle back
	int          led_still_q; // Cycles the indicator held still

	// Config and lock; the lock copy ignores writes once frozen
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			cfg_q  <= 16'h0000;
			lock_q <= 2'h0;
		end else if (cfg_acc_in.wr) begin
			if (cfg_acc_in.addr == 8'h60) cfg_q <= cfg_acc_in.wdata[15:0];
			if (cfg_acc_in.addr == 8'h68 && !lock_q[0]) lock_q <= cfg_acc_in.wdata[1:0];
		end
	end

	// Pin block copies
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			dir_q <= 32'hFFFF_FFFF;
			lvl_q <= 32'hFFFF_FFFF;
			blk_q <= 32'h0000_0000;
		end else if (pin_acc_in.wr) begin
			if (pin_acc_in.addr == 8'h04) dir_q <= pin_acc_in.wdata;
			if (pin_acc_in.addr == 8'h0C) lvl_q <= pin_acc_in.wdata;
			if (pin_acc_in.addr == 8'h18) blk_q <= pin_acc_in.wdata;
		end
	end

	// Counts still cycles while blinking is on; a counter keeps the bound small
	always_ff @(posedge clk_in) begin
		led_prev_q <= indicator_output;
		if (!rst_b_in || indicator_output != led_prev_q || dir_q[25] || !blk_q[25]) begin
			led_still_q <= 0;
		end else begin
			led_still_q <= led_still_q + 1;
		end
	end

	// ----
	// Properties
	// ----
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);

	property p_tout_held; !timeout_out_n |=> !timeout_out_n; endproperty
	a_tout_held: assert property (p_tout_held) else $error("timeout released");
	property p_mgmt; 1'b1 |-> !management_interrupt_out; endproperty
	a_mgmt: assert property (p_mgmt) else $error("management line raised");
	property p_irq_type; $stable(cfg_q) && cfg_q[1:0] != 2'h0 |-> irq_n_out; endproperty
	a_irq_type: assert property (p_irq_type) else $error("irq with type off");
	property p_tout_dis; $stable(cfg_q) && cfg_q[5] |-> timeout_out_n; endproperty
	a_tout_dis: assert property (p_tout_dis) else $error("timeout while disabled");
	property p_stage_order; $fell(timeout_out_n) && cfg_q[1:0] == 2'h0 |-> !irq_n_out; endproperty
	a_stage_order: assert property (p_stage_order) else $error("timeout before irq");
	property p_needs_en; $fell(irq_n_out) || $fell(timeout_out_n) |-> lock_q[1]; endproperty
	a_needs_en: assert property (p_needs_en) else $error("expiry while disabled");
	property p_lock_rd; lock_q[0] && cfg_acc_in.addr == 8'h68 |=> cfg_rdata_out[1:0] == lock_q;
	endproperty
	a_lock_rd: assert property (p_lock_rd) else $error("frozen lock changed");
	property p_gate; $stable(dir_q) && $stable(lvl_q) |-> reset_gate_output == (dir_q[24] | lvl_q[24]);
	endproperty
	a_gate: assert property (p_gate) else $error("gate level wrong");
	property p_led; $stable({dir_q, lvl_q, blk_q}) && !dir_q[25] && !blk_q[25]
		|-> indicator_output == lvl_q[24]; endproperty
	a_led: assert property (p_led) else $error("indicator level wrong");
	property p_blink; !dir_q[25] && blk_q[25] |-> led_still_q <= BLK_MAX; endproperty
	a_blink: assert property (p_blink) else $error("indicator not blinking");
endmodule // tswd_watchdog_unit_props

bind tswd_watchdog_unit tswd_watchdog_unit_props #(.BLINK_CYCLES(BLINK_CYCLES)) u_props (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .cfg_acc_in(cfg_acc_in), .pin_acc_in(pin_acc_in),
	.cfg_rdata_out(cfg_rdata_out), .irq_n_out(irq_n_out),
	.management_interrupt_out(management_interrupt_out), .timeout_out_n(timeout_out_n),
	.reset_gate_output(reset_gate_output), .indicator_output(indicator_output));

// *** tb/tswd_reset_circuit.sv ***
// Board reset circuit fed by the watchdog pins.
// Assumes plain levels straight from the watchdog unit.
module tswd_reset_circuit (
	input  wire logic timeout_n_in, // Timeout, active low
	input  wire logic gate_in,      // Low lets the timeout act
	output logic      sys_rst_out   // System reset request
);
	timeunit 1ns;
	timeprecision 1ns;
	// A high gate blocks the timeout from resetting the board
	assign sys_rst_out = !gate_in && !timeout_n_in;
endmodule // tswd_reset_circuit

// *** tb/tswd_watchdog_unit_tb.sv ***
// Self-checking bench for the watchdog unit.
// Assumes the package, the design and the reset circuit model are compiled first.
module tswd_watchdog_unit_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import tswd_pkg::*;
	logic         clk_in, rst_b_in, gp_in, sys_rst; // Clock, reset, pin, board reset
	tswd_access_s cfg, win, pin;                    // Access ports
	logic [31:0]  cfg_rd, win_rd, pin_rd, rdv;      // Read data
	logic         irq_n, mgmt, tout_n, gp_out, gp_oe, gate, led; // Pins
	int           fail_count, n_tests, n;           // Counters

	tswd_watchdog_unit #(.MS_CYCLES(20), .BLINK_CYCLES(8)) DUT (.clk_in(clk_in),
		.rst_b_in(rst_b_in), .cfg_acc_in(cfg), .win_acc_in(win), .pin_acc_in(pin),
		.shared_general_pin_in(gp_in), .cfg_rdata_out(cfg_rd), .win_rdata_out(win_rd),
		.pin_rdata_out(pin_rd), .irq_n_out(irq_n), .management_interrupt_out(mgmt),
		.timeout_out_n(tout_n), .shared_general_pin_out(gp_out),
		.shared_general_pin_oe_out(gp_oe), .reset_gate_output(gate), .indicator_output(led));
	tswd_reset_circuit u_rst (.timeout_n_in(tout_n), .gate_in(gate), .sys_rst_out(sys_rst));

	// 100 ns clock
	initial begin
		clk_in = 0;
		forever #50 clk_in = ~clk_in;
	end
	// ----
	// Access tasks; every change lands on a falling edge
	// ----
	task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Strobe stays up until the next access or idle
	task automatic acc(int sp, logic w, logic [7:0] a, logic [31:0] d);
		@(negedge clk_in);
		cfg = '{w && sp == 0, !w, a, d};
		win = '{w && sp == 1, !w, a, d};
		pin = '{w && sp == 2, !w, a, d};
	endtask
	task automatic wr(int sp, logic [7:0] a, logic [31:0] d); acc(sp, 1, a, d); endtask
	task automatic rd(int sp, logic [7:0] a, output logic [31:0] v);
		acc(sp, 0, a, 32'h0000_0000);
		@(negedge clk_in);
		v = sp == 0 ? cfg_rd : sp == 1 ? win_rd : pin_rd;
	endtask
	task automatic idle(int c);
		repeat (c) begin
			@(negedge clk_in);
			cfg.wr = 0; win.wr = 0; pin.wr = 0;
		end
	endtask
	task automatic reset_dut; rst_b_in = 0; idle(6); rst_b_in = 1; endtask
	task automatic unlock; wr(1, 8'h0C, 32'h0000_0080); wr(1, 8'h0C, 32'h0000_0086); endtask
	task automatic load_preloads(logic [31:0] p1, logic [31:0] p2);
		unlock; wr(1, 8'h00, p1); unlock; wr(1, 8'h04, p2); idle(1);
	endtask
	task automatic enable(logic [31:0] v); wr(0, 8'h68, v); idle(1); endtask
	task automatic reload(int c); idle(c); unlock; wr(1, 8'h0C, 32'h0000_0100); endtask
	// Cycles until irq (0) or timeout (1) goes low, bounded
	task automatic wait_low(int which, int max);
		n = 0;
		while ((which ? tout_n : irq_n) !== 1'b0 && n < max) begin idle(1); n++; end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset;
		reset_dut;
		chk("irq_n", irq_n, 1); chk("tout_n", tout_n, 1); chk("gate", gate, 1);
		chk("led", led, 1); chk("mgmt", mgmt, 0);
		rd(0, 8'h68, rdv); chk("lock_rst", rdv, 0);
		rd(0, 8'h60, rdv); chk("cfg_rst", rdv, 0);
	endtask
	task automatic t_preload;
		reset_dut;
		wr(1, 8'h00, 32'hFFFF_F123); rd(1, 8'h00, rdv); chk("pre1_shut", rdv, 0);
		unlock; wr(1, 8'h00, 32'hFFFF_F123);
		rd(1, 8'h00, rdv); chk("pre1", rdv, 32'h000F_F123);
		unlock; wr(1, 8'h08, 32'h0000_0000); wr(1, 8'h04, 32'h0000_0055);
		rd(1, 8'h04, rdv); chk("pre2_broken", rdv, 0);
	endtask
	task automatic t_two_stage;
		reset_dut;
		wr(2, 8'h04, 32'hFEFF_FFFF); wr(2, 8'h0C, 32'hFEFF_FFFF);
		wr(2, 8'h30, 32'h0000_0000); wr(0, 8'h60, 32'h0000_0004);
		wr(0, 8'h10, 32'h0000_1000); rd(0, 8'h10, rdv);
		chk("base", rdv, 32'h0000_1000);
		load_preloads(32'h0000_0002, 32'h0000_0003);
		enable(32'h0000_0002);
		wait_low(0, 60); chk("stage1_span", n >= 20 && n <= 36, 1);
		wait_low(1, 60); chk("stage2_span", n >= 36 && n <= 42, 1);
		chk("sys_reset", sys_rst, 1);
		chk("pin_tout", gp_out, 0); chk("pin_oe", gp_oe, 1);
		enable(32'h0000_0000); idle(50); chk("tout_held", tout_n, 0);
		rd(1, 8'h08, rdv); chk("status", rdv, 1);
	endtask
	task automatic t_reload;
		reset_dut;
		wr(0, 8'h60, 32'h0000_0004); load_preloads(32'h0000_0005, 32'h0000_0001);
		enable(32'h0000_0002);
		repeat (5) reload(25);
		chk("irq_serviced", irq_n, 1);
		wait_low(0, 90); reload(0);
		repeat (5) reload(25);
		chk("tout_serviced", tout_n, 1);
	endtask
	task automatic t_masks;
		gp_in = 1;
		for (int t = 0; t < 4; t++) begin
			reset_dut;
			wr(2, 8'h30, t == 0);
			wr(0, 8'h60, t == 0 ? 32'h0000_0004 : 32'h0000_0024 | t);
			load_preloads(32'h0000_0000, 32'h0000_0000); enable(32'h0000_0002); idle(60);
			chk("irq_type", irq_n, t != 0);
			chk("tout_masked", tout_n, 1);
			chk("mgmt", mgmt, 0);
			chk("pin_oe", gp_oe, 1); chk("pin_lvl", gp_out, 1);
			rd(2, 8'h30, rdv); chk("use_rd", rdv, t == 0);
		end
	endtask
	task automatic t_lock;
		reset_dut;
		load_preloads(32'h0000_0002, 32'h0000_0000); enable(32'h0000_0002); idle(10);
		enable(32'h0000_0000); idle(80); chk("stopped", irq_n, 1);
		enable(32'h0000_0003); enable(32'h0000_0000);
		rd(0, 8'h68, rdv); chk("lock", rdv[1:0], 2'h3);
		wait_low(0, 90); chk("ms_span", n >= 33 && n <= 66, 1);
	endtask
	task automatic t_led;
		logic v;
		reset_dut;
		wr(2, 8'h04, 32'hFCFF_FFFF); wr(2, 8'h0C, 32'hFEFF_FFFF); idle(3);
		chk("led_on", led, 0); chk("gate_low", gate, 0);
		wr(2, 8'h0C, 32'hFFFF_FFFF); idle(3); chk("led_off", led, 1);
		wr(2, 8'h18, 32'h0200_0000); idle(3);
		repeat (2) begin
			v = led; n = 0;
			while (led === v && n < 20) begin idle(1); n++; end
		end
		chk("blink_phase", n >= 7 && n <= 9, 1);
		rd(2, 8'h18, rdv); chk("blink_rd", rdv, 32'h0200_0000);
	endtask
	// ----
	// Verdict, main sequence and hang guard
	// ----
	task automatic print_verdict;
		if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	initial begin
		rst_b_in = 0; gp_in = 0; cfg = '0; win = '0; pin = '0; fail_count = 0; n_tests = 0;
		t_reset; t_preload; t_two_stage; t_reload; t_masks; t_lock; t_led;
		print_verdict;
	end
	// About twenty times the expected run length
	initial begin
		repeat (20000) @(posedge clk_in);
		fail_count++;
		print_verdict;
	end
endmodule // tswd_watchdog_unit_tb
